// File: rtl/lvb_pkg.sv
// package for the low-voltage buck control registers
// assumes an apb master on the same 10 MHz clock
package lvb_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_VOLT   = 8'h00;
  localparam logic [7:0] ADDR_MODE   = 8'h04;
  localparam logic [7:0] ADDR_CFG    = 8'h08;
  localparam logic [7:0] ADDR_IRQ    = 8'h0c;
  localparam logic [7:0] ADDR_STAT   = 8'h10;

  // field positions
  localparam int VOLT_LSB    = 0;
  localparam int RUNM_LSB    = 0;
  localparam int STBM_LSB    = 2;
  localparam int ILIM_LSB    = 0;
  localparam int PHASE_LSB   = 2;
  localparam int IND_LSB     = 5;
  localparam int IRQF_BIT    = 0;
  localparam int IRQM_BIT    = 1;

  // operating mode codes
  typedef enum logic [1:0] {
    LVB_OFF  = 2'b00,
    LVB_PWM  = 2'b01,
    LVB_PFM  = 2'b10,
    LVB_AUTO = 2'b11
  } lvb_mode_t;

  // reset values
  localparam logic [1:0] MODE_SEQ_RST   = 2'h3;
  localparam logic [1:0] MODE_NOSEQ_RST = 2'h0;
  localparam logic [2:0] PHASE_RST      = 3'h7;
  localparam logic [1:0] ILIM_RST       = 2'h0;
  localparam logic       MASK_RST       = 1'b1;

  // highest distinct voltage code; codes above share the maximum
  localparam logic [4:0] VOLT_MAX_CODE  = 5'h1b;

  // ramp down time before discharge, in microseconds
  localparam int RAMP_US       = 200;
  localparam int CLK_MHZ       = 10;
  localparam int RAMP_CYC      = RAMP_US * CLK_MHZ;
  // discharge hold time in microseconds
  localparam int DIS_US        = 100;
  localparam int DIS_CYC       = DIS_US * CLK_MHZ;

  typedef enum logic [1:0] {
    LVB_ST_RUN  = 2'b00,
    LVB_ST_RAMP = 2'b01,
    LVB_ST_DIS  = 2'b10
  } lvb_state_t;

endpackage

// File: rtl/lvb_ctrl.sv
// control registers and sequencer of the low-voltage buck
// assumes apb master, otp defaults and strap stable around reset release
// How it works
// - one 5-bit code sets voltage, run and standby
// - new code: disable, discharge, re-enable
// - set point loads from otp at power up
// - codes above 27 clamp to 4.10 V
// - run mode resets autoskip if sequenced, else off
// - standby mode resets the same way
// - mode codes off, pwm, pfm, autoskip
// - mode change sets flag; pin if unmasked
// - run/standby swap keeps the voltage
// - 2-bit peak current limit select
// - 3-bit phase, resets to 0 degrees, writable
// - phase code 111 is 0 degrees
// - 2-bit otp inductor select, 11 reserved
// - discharge only after disable and ramp down
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module lvb_ctrl
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  stored_voltage_default,
  input  wire logic [1:0]  inductor_value_select,
  input  wire logic        in_power_up_seq,
  input  wire logic        standby_req,
  output logic      [4:0]  output_voltage_code,
  output logic      [1:0]  op_select_field,
  output logic             buck_enable,
  output logic             discharge_on,
  output logic      [1:0]  peak_limit_select,
  output logic      [2:0]  switch_phase_select,
  output logic      [1:0]  inductor_sel_out,
  output logic             irq_out_n
);

  logic [4:0]  volt_q;
  logic [1:0]  active_state_op_select;
  logic [1:0]  standby_state_op_select;
  logic [1:0]  ilim_q;
  logic [2:0]  phase_q;
  logic [1:0]  ind_q;
  logic        op_change_irq;
  logic        mask_q;
  logic        init_q;
  logic        stby_q;
  logic [1:0]  mode_q;
  logic [1:0]  mode_d;
  logic [15:0] cnt_q;
  logic        volt_wr;
  logic        wr;
  logic        rd;
  logic        setup;
  logic        mapped;
  logic        wr_volt;
  logic        wr_mode;
  logic        wr_cfg;
  logic        wr_irq;
  logic [31:0] rdata_d;
  lvb_pkg::lvb_state_t st_q;

  // writes land in the access cycle, which is also the pready cycle
  assign wr = psel && penable && pwrite;
  // read data is fetched at setup so that it stands with pready
  assign setup = psel && !penable;
  assign rd = setup && !pwrite;
  assign mapped = (paddr == lvb_pkg::ADDR_VOLT) ||
                  (paddr == lvb_pkg::ADDR_MODE) ||
                  (paddr == lvb_pkg::ADDR_CFG)  ||
                  (paddr == lvb_pkg::ADDR_IRQ)  ||
                  (paddr == lvb_pkg::ADDR_STAT);
  // one strobe per register keeps the decode in a single place
  assign wr_volt = wr && (paddr == lvb_pkg::ADDR_VOLT);
  assign wr_mode = wr && (paddr == lvb_pkg::ADDR_MODE);
  assign wr_cfg  = wr && (paddr == lvb_pkg::ADDR_CFG);
  assign wr_irq  = wr && (paddr == lvb_pkg::ADDR_IRQ);
  // only a real change restarts the output; the same code is silent
  assign volt_wr = wr_volt &&
                   (pwdata[lvb_pkg::VOLT_LSB +: 5] != volt_q);

  // one-shot load of straps and otp after reset release
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      init_q <= 1'b0;
    else
      init_q <= 1'b1;
  end

  // set point register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      volt_q <= 5'h00;
    else if (!init_q)
      volt_q <= stored_voltage_default;
    else if (wr_volt)
      volt_q <= pwdata[lvb_pkg::VOLT_LSB +: 5];
  end

  // mode fields
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      active_state_op_select  <= lvb_pkg::MODE_NOSEQ_RST;
      standby_state_op_select <= lvb_pkg::MODE_NOSEQ_RST;
    end
    else if (!init_q)
    begin
      active_state_op_select  <= in_power_up_seq ?
        lvb_pkg::MODE_SEQ_RST : lvb_pkg::MODE_NOSEQ_RST;
      standby_state_op_select <= in_power_up_seq ?
        lvb_pkg::MODE_SEQ_RST : lvb_pkg::MODE_NOSEQ_RST;
    end
    else if (wr_mode)
    begin
      active_state_op_select  <= pwdata[lvb_pkg::RUNM_LSB +: 2];
      standby_state_op_select <= pwdata[lvb_pkg::STBM_LSB +: 2];
    end
  end

  // limit, phase and inductor config
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ilim_q  <= lvb_pkg::ILIM_RST;
      phase_q <= lvb_pkg::PHASE_RST;
      ind_q   <= 2'h0;
    end
    else if (!init_q)
      ind_q <= inductor_value_select;
    else if (wr_cfg)
    begin
      ilim_q  <= pwdata[lvb_pkg::ILIM_LSB +: 2];
      phase_q <= pwdata[lvb_pkg::PHASE_LSB +: 3];
    end
  end

  // standby state follows its request
  // one register stage; the request is a synchronous level
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      stby_q <= 1'b0;
    else
      stby_q <= standby_req;
  end

  // mode selected by state, voltage untouched
  always_comb
  begin
    mode_d = stby_q ? standby_state_op_select : active_state_op_select;
    if (st_q != lvb_pkg::LVB_ST_RUN || !init_q)
      mode_d = lvb_pkg::LVB_OFF;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mode_q <= 2'h0;
    else
      mode_q <= mode_d;
  end

  // voltage change sequencer
  // a new code is never applied to a live output: the stage is turned
  // off, allowed to ramp down, discharged and only then restarted.
  // counts are fixed for the worst ramp, trading speed for safety.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q  <= lvb_pkg::LVB_ST_RUN;
      cnt_q <= 16'h0000;
    end
    else
    begin
      unique case (st_q)
        lvb_pkg::LVB_ST_RUN:
          if (volt_wr && mode_q != lvb_pkg::LVB_OFF)
          begin
            st_q  <= lvb_pkg::LVB_ST_RAMP;
            cnt_q <= 16'(lvb_pkg::RAMP_CYC - 1);
          end
        lvb_pkg::LVB_ST_RAMP:
          if (cnt_q == 16'h0000)
          begin
            st_q  <= lvb_pkg::LVB_ST_DIS;
            cnt_q <= 16'(lvb_pkg::DIS_CYC - 1);
          end
          else
            cnt_q <= cnt_q - 16'h0001;
        lvb_pkg::LVB_ST_DIS:
          if (cnt_q == 16'h0000)
            st_q <= lvb_pkg::LVB_ST_RUN;
          else
            cnt_q <= cnt_q - 16'h0001;
        default:
          st_q <= lvb_pkg::LVB_ST_RUN;
      endcase
    end
  end

  // interrupt flag and mask
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      op_change_irq <= 1'b0;
      mask_q        <= lvb_pkg::MASK_RST;
    end
    else
    begin
      if (wr_irq)
        mask_q <= pwdata[lvb_pkg::IRQM_BIT];
      // set wins over write-one clear
      // so a change in the clear cycle is never lost
      if (init_q && mode_d != mode_q)
        op_change_irq <= 1'b1;
      else if (wr_irq && pwdata[lvb_pkg::IRQF_BIT])
        op_change_irq <= 1'b0;
    end
  end

  // set point and mode to the power stage
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      output_voltage_code <= 5'h00;
      op_select_field     <= 2'h0;
      buck_enable         <= 1'b0;
    end
    else
    begin
      // codes above the top one all mean the maximum
      output_voltage_code <= (volt_q > lvb_pkg::VOLT_MAX_CODE) ?
        lvb_pkg::VOLT_MAX_CODE : volt_q;
      op_select_field     <= mode_d;
      buck_enable         <= mode_d != lvb_pkg::LVB_OFF;
    end
  end

  // discharge only in its own state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      discharge_on <= 1'b0;
    else
      discharge_on <= st_q == lvb_pkg::LVB_ST_DIS;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      peak_limit_select   <= lvb_pkg::ILIM_RST;
      switch_phase_select <= lvb_pkg::PHASE_RST;
      inductor_sel_out    <= 2'h0;
    end
    else
    begin
      peak_limit_select   <= ilim_q;
      // code passed straight on; 111 is the zero-degree setting
      switch_phase_select <= phase_q;
      inductor_sel_out    <= ind_q;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_out_n <= 1'b1;
    else
      irq_out_n <= !(op_change_irq && !mask_q);
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rdata_d = 32'h00000000;
    unique case (paddr)
      lvb_pkg::ADDR_VOLT: rdata_d = {27'h0, volt_q};
      lvb_pkg::ADDR_MODE:
        rdata_d = {28'h0, standby_state_op_select,
                   active_state_op_select};
      lvb_pkg::ADDR_CFG:  rdata_d = {25'h0, ind_q, phase_q, ilim_q};
      lvb_pkg::ADDR_IRQ:  rdata_d = {30'h0, mask_q, op_change_irq};
      lvb_pkg::ADDR_STAT:
        rdata_d = {27'h0, stby_q, st_q, mode_q[1], mode_q[0]};
      default:            rdata_d = 32'h00000000;
    endcase
  end

  // apb slave, zero wait states
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // answer always follows setup by one edge: no wait states
      pready  <= setup;
      pslverr <= setup && !mapped;
      // outside a read the bus shows zero, not stale data
      prdata  <= rd ? rdata_d : 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// File: test/lvb_ctrl_sva.sv
// port checker for lvb_ctrl
// assumes binding onto lvb_ctrl, one clock domain
`timescale 1ns/100ps
`default_nettype none
module lvb_ctrl_chk
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [7:0] paddr,
  input wire logic       buck_enable,
  input wire logic       discharge_on,
  input wire logic [1:0] op_select_field,
  input wire logic [2:0] switch_phase_select
);
  // slack of two edges for the registered enable and discharge flags
  localparam int RAMP_MIN = 1998;
  int off_cnt_q;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      off_cnt_q <= 0;
    else
      off_cnt_q <= buck_enable ? 0 : off_cnt_q + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  en_mode_a: assert property (buck_enable |-> op_select_field != 2'h0)
    else $error("enabled while mode off");
  dis_off_a: assert property (discharge_on |-> !buck_enable)
    else $error("discharge while enabled");
  dis_ramp_a: assert property ($rose(discharge_on) |-> off_cnt_q >= RAMP_MIN)
    else $error("discharge before ramp down");
  re_en_a: assert property ($fell(discharge_on) |-> ##[0:2] buck_enable)
    else $error("no re-enable after discharge");
  phase_rst_a: assert property ($fell(sys_rst) |-> switch_phase_select == 3'h7)
    else $error("phase reset value");
  rdy_one_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  rdy_set_a: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  unmap_a: assert property (pready && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not refused");
  cover property ($rose(discharge_on));
  cover property (pready && pslverr);
  cover property ($rose(buck_enable));
endmodule
bind lvb_ctrl lvb_ctrl_chk chk (.*);
`default_nettype wire

// File: test/lvb_apb_host.sv
// apb master model standing in for host software
// assumes the slave answers on the shared clk
`timescale 1ns/100ps
`default_nettype none
module lvb_apb_host
(
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e, t);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (n = 0; pready !== 1'b1 && n < 20; n++)
      @(posedge clk);
    r = prdata;
    e = pslverr;
    t = n >= 20;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data inverted so a stale value cannot pass
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// File: test/lvb_ctrl_tb.sv
// self-checking bench for lvb_ctrl with random config traffic
// assumes lvb_apb_host as the only bus master
`timescale 1ns/100ps
`default_nettype none
module lvb_ctrl_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        in_power_up_seq = 1'b0;
  logic        standby_req = 1'b0;
  logic [4:0]  stored_voltage_default = 5'h00;
  logic [1:0]  inductor_value_select = 2'h0;
  logic        psel, penable, pwrite, pready, pslverr, buck_enable;
  logic        discharge_on, irq_out_n, er, to;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, wd;
  logic [4:0]  output_voltage_code, nv;
  logic [1:0]  op_select_field, peak_limit_select, inductor_sel_out;
  logic [2:0]  switch_phase_select;
  int          seed = 93;
  int          bad_count = 0;
  int          samples_checked = 0;
  lvb_ctrl dut (.*);
  lvb_apb_host host (.*);
  always #50 clk = ~clk;
  function automatic logic [4:0] clamp(input logic [4:0] v);
    return v > 5'h1b ? 5'h1b : v;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic fail_now();
    bad_count++;
    print_verdict();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    host.xfer(w, a, d, rd, er, to);
    if (to !== 1'b0)
      fail_now();
  endtask
  task automatic wait_lvl(input logic e, v, input int lim);
    int n;
    for (n = 0; (e ? buck_enable : discharge_on) !== v && n < lim; n++)
      @(posedge clk);
    if (n >= lim)
      fail_now();
  endtask
  task automatic do_reset(input logic s);
    sys_rst <= 1'b1;
    in_power_up_seq <= s;
    stored_voltage_default <= 5'($random(seed));
    inductor_value_select <= 2'($random(seed));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial
  begin
    for (int s = 0; s < 2; s++)
    begin
      do_reset(s[0]);
      chk(output_voltage_code, clamp(stored_voltage_default));
      chk(op_select_field, s ? 2'h3 : 2'h0);
      bus(1'b0, lvb_pkg::ADDR_MODE, 32'h0);
      chk(rd, s ? 32'hf : 32'h0);
      bus(1'b0, lvb_pkg::ADDR_STAT, 32'h0);
      chk(rd, s ? 32'h3 : 32'h0);
      chk(switch_phase_select, 3'h7);
      chk(inductor_sel_out, inductor_value_select);
    end
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, lvb_pkg::ADDR_MODE, 32'(((3 - m) << 2) | m));
      repeat (3) @(posedge clk);
      chk(op_select_field, m);
      chk(buck_enable, m != 0);
      standby_req <= 1'b1;
      repeat (3) @(posedge clk);
      chk(op_select_field, 3 - m);
      chk(output_voltage_code, clamp(stored_voltage_default));
      standby_req <= 1'b0;
    end
    chk(irq_out_n, 1'b1);
    bus(1'b1, lvb_pkg::ADDR_IRQ, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq_out_n, 1'b0);
    bus(1'b1, lvb_pkg::ADDR_IRQ, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq_out_n, 1'b1);
    bus(1'b1, lvb_pkg::ADDR_MODE, 32'h5);
    repeat (3) @(posedge clk);
    chk(irq_out_n, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      wd = i == 0 ? 32'h7f : 32'($random(seed));
      bus(1'b1, lvb_pkg::ADDR_CFG, wd);
      bus(1'b0, lvb_pkg::ADDR_CFG, 32'h0);
      chk(rd, {25'h0, inductor_value_select, wd[4:0]});
      chk(peak_limit_select, wd[1:0]);
      chk(switch_phase_select, wd[4:2]);
    end
    bus(1'b1, 8'h20, 32'h1);
    chk(er, 1'b1);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    nv = stored_voltage_default < 5'h1c ? 5'h1f : 5'h00;
    bus(1'b1, lvb_pkg::ADDR_VOLT, 32'(nv));
    wait_lvl(1'b0, 1'b1, 2100);
    wait_lvl(1'b0, 1'b0, 1100);
    wait_lvl(1'b1, 1'b1, 5);
    chk(output_voltage_code, clamp(nv));
    print_verdict();
  end
endmodule
`default_nettype wire
